// ---- core/pointer_link_consts.svh ----
// constants for the pointer serial packet link: timing, offsets, fields, reset values
`ifndef POINTER_LINK_CONSTS_SVH
`define POINTER_LINK_CONSTS_SVH
`define CLK_HZ          50000000
`define BAUD_SLOW       1200
`define BAUD_FAST       2400
`define BREAK_MS        40
`define DEBOUNCE_US     1000
`define BREAK_CYCLES    ((`BREAK_MS * `CLK_HZ) / 1000)
`define DEBOUNCE_CYCLES ((`DEBOUNCE_US * (`CLK_HZ / 1000)) / 1000)
`define BIT_SLOW_CYCLES (`CLK_HZ / `BAUD_SLOW)
`define BIT_FAST_CYCLES (`CLK_HZ / `BAUD_FAST)
`define REPORT_BYTES    3'h5
`define LAST_BIT        4'h9
`define SYNC_PATTERN    5'h10
`define ADDR_CTRL       4'h0
`define ADDR_STATUS     4'h4
`define ADDR_COUNT      4'h8
`define ADDR_ACCUM      4'hC
`define CTRL_RESET      3'h4
`define CTRL_FAST_BIT   0
`define CTRL_TTL_BIT    1
`define CTRL_EN_BIT     2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RESP_DECERR     2'h3
`endif

// ---- core/pointer_link_pkg.sv ----
// types shared by the pointer serial packet link
package pointer_link_pkg;
	typedef enum logic [1:0] {
		LINK_BREAK,
		LINK_IDLE,
		LINK_SEND
	} link_state_t;
endpackage : pointer_link_pkg

// ---- core/pointer_serial_packet_link.sv ----
// pointer serial packet link: report framer, uart transmitter, axi4-lite registers
// Behaviour
// [R1] five-byte report only on change, else silent
// [R2] sync byte high five bits 10000
// [R3] sync low bits left middle right, 0=pressed
// [R4] then dx, dy, dx, dy bytes
// [R5] delta is motion since last sent delta
// [R6] accumulator cleared whenever its value sent
// [R7] deltas are 8-bit two's complement
// [R8] positive means right and up
// [R9] no split sixteen-bit values, bytes independent
// [R10] receiver tolerates extra bytes after report
// [R11] receiver scans for sync, takes four deltas
// [R12] standard variant sends nothing outside reports
// [R13] 8 data bits, no parity, 1200/2400 baud
// [R14] one start, one stop, lsb first
// [R15] ttl mode: low start bit, idle high
// [R16] rs-232 mode inverted, open-collector output
// [R17] 40 ms start-level break after power-up
// [R18] self-check and automatic restart on failure
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "pointer_link_consts.svh"
module pointer_serial_packet_link
	import pointer_link_pkg::*;
#(
	parameter int BREAK_CYCLES    = `BREAK_CYCLES,
	parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
	parameter int BIT_SLOW_CYCLES = `BIT_SLOW_CYCLES,
	parameter int BIT_FAST_CYCLES = `BIT_FAST_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  button_n,     // left, middle, right; low while pressed
	input  wire logic        x_step,       // rising edge per horizontal count
	input  wire logic        x_right,      // direction of a horizontal count
	input  wire logic        y_step,       // rising edge per vertical count
	input  wire logic        y_up,         // direction of a vertical count
	output logic             tx_out,       // serial pin output level
	output logic             tx_oe,        // serial pin driven while high
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam logic [21:0] BREAK_LAST = 22'(BREAK_CYCLES - 1);
	localparam logic [16:0] DEB_LAST   = 17'(DEBOUNCE_CYCLES - 1);
	localparam logic [15:0] SLOW_LAST  = 16'(BIT_SLOW_CYCLES - 1);
	localparam logic [15:0] FAST_LAST  = 16'(BIT_FAST_CYCLES - 1);
	logic [6:0]  sync1, sync2;     // two-stage synchronisers for all pins
	logic        x_prev, y_prev;   // last synchronised step levels
	logic [2:0]  btn_db;           // debounced buttons
	logic [16:0] deb_cnt;          // stability counter
	logic [2:0]  btn_sent;         // buttons carried by the last sync byte
	logic [7:0]  acc_x, acc_y;     // signed motion accumulators
	logic [2:0]  ctrl;             // fast, ttl, enable
	logic [15:0] report_count;     // reports sent
	link_state_t state;
	logic [21:0] brk_cnt;          // break duration counter
	logic [15:0] bit_cnt;          // cycles within a bit
	logic [3:0]  bit_idx;          // bit within a character
	logic [2:0]  byte_idx;         // byte within a report
	logic [9:0]  shift;            // character being sent, lsb first
	logic        line;             // logical line level, 1 = mark
	logic        fault;            // internal inconsistency seen
	logic        take_x, take_y;   // accumulator sent this cycle
	logic        x_pulse, y_pulse; // synchronised step edges
	logic        bit_end, start_rpt, byte_done;
	logic [15:0] bit_last;
	logic        aw_held, w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	// saturating add of one count to a signed accumulator
	function automatic logic [7:0] step_acc(input logic [7:0] acc, input logic up);
		if (up)
			step_acc = (acc == 8'h7F) ? acc : 8'(acc + 8'h01);
		else
			step_acc = (acc == 8'h80) ? acc : 8'(acc - 8'h01);
	endfunction : step_acc
	// register read decode, used by the read path
	function automatic logic [31:0] read_reg(input logic [3:0] a);
		case (a)
			`ADDR_CTRL:   read_reg = {29'h0, ctrl};
			`ADDR_STATUS: read_reg = {24'h0, fault, btn_db, line, byte_idx == 3'h0,
				state == LINK_SEND, state == LINK_BREAK};
			`ADDR_COUNT:  read_reg = {16'h0, report_count};
			`ADDR_ACCUM:  read_reg = {16'h0, acc_y, acc_x};
			default:      read_reg = 32'h0;
		endcase
	endfunction : read_reg
	// pins pass two flip-flops before use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1 <= 7'h07; // steps idle low, buttons released: no false edge
			sync2 <= 7'h07;
		end else begin
			sync1 <= {y_up, y_step, x_right, x_step, button_n};
			sync2 <= sync1;
		end
	end
	// step edge detection on the second stage only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			x_prev <= 1'b0;
			y_prev <= 1'b0;
		end else begin
			x_prev <= sync2[3];
			y_prev <= sync2[5];
		end
	end
	assign x_pulse = sync2[3] & ~x_prev;
	assign y_pulse = sync2[5] & ~y_prev;
	// button debounce: accept a new state after it stays stable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			btn_db  <= 3'h7;
			deb_cnt <= 17'h0;
		end else if (sync2[2:0] == btn_db) begin
			deb_cnt <= 17'h0;
		end else if (deb_cnt == DEB_LAST) begin
			btn_db  <= sync2[2:0]; // R3
			deb_cnt <= 17'h0;
		end else begin
			deb_cnt <= 17'(deb_cnt + 17'h1);
		end
	end
	// accumulators: a count arriving as the value is sent is kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_x <= 8'h00;
			acc_y <= 8'h00;
		end else begin
			if (take_x) // R6
				acc_x <= x_pulse ? (sync2[4] ? 8'h01 : 8'hFF) : 8'h00;
			else if (x_pulse)
				acc_x <= step_acc(acc_x, sync2[4]); // R5 R8
			if (take_y) // R6
				acc_y <= y_pulse ? (sync2[6] ? 8'h01 : 8'hFF) : 8'h00;
			else if (y_pulse)
				acc_y <= step_acc(acc_y, sync2[6]); // R5 R8
		end
	end
	// framer timing terms
	assign bit_last  = ctrl[`CTRL_FAST_BIT] ? FAST_LAST : SLOW_LAST; // R13
	assign bit_end   = (state == LINK_SEND) && (bit_cnt == bit_last);
	assign byte_done = bit_end && (bit_idx == `LAST_BIT);
	assign start_rpt = (state == LINK_IDLE) && ctrl[`CTRL_EN_BIT] &&
		((btn_db != btn_sent) || (acc_x != 8'h00) || (acc_y != 8'h00)); // R1
	assign take_x = byte_done && (byte_idx == 3'h0 || byte_idx == 3'h2); // R4
	assign take_y = byte_done && (byte_idx == 3'h1 || byte_idx == 3'h3); // R4
	assign fault  = (bit_idx > `LAST_BIT) || (byte_idx >= `REPORT_BYTES); // R18
	// report framer and character shifter
	always_ff @(posedge clk) begin
		if (!rst_n || fault) begin // R18
			state    <= LINK_BREAK;
			brk_cnt  <= 22'h0;
			bit_cnt  <= 16'h0;
			bit_idx  <= 4'h0;
			byte_idx <= 3'h0;
			shift    <= 10'h3FF;
			line     <= 1'b0;
			btn_sent <= 3'h7;
		end else begin
			case (state)
				LINK_BREAK: begin
					line <= 1'b0; // R17
					if (brk_cnt == BREAK_LAST) begin
						state <= LINK_IDLE;
						line  <= 1'b1;
					end else begin
						brk_cnt <= 22'(brk_cnt + 22'h1);
					end
				end
				LINK_IDLE: begin
					line <= 1'b1; // R12
					if (start_rpt) begin
						state    <= LINK_SEND;
						btn_sent <= btn_db;
						shift    <= {1'b1, `SYNC_PATTERN, btn_db, 1'b0}; // R2 R3 R14
						line     <= 1'b0;
						bit_cnt  <= 16'h0;
						bit_idx  <= 4'h0;
						byte_idx <= 3'h0;
					end
				end
				LINK_SEND: begin
					if (!bit_end) begin
						bit_cnt <= 16'(bit_cnt + 16'h1);
					end else if (bit_idx != `LAST_BIT) begin
						bit_cnt <= 16'h0;
						bit_idx <= 4'(bit_idx + 4'h1);
						shift   <= {1'b1, shift[9:1]}; // R14
						line    <= shift[1];
					end else if (byte_idx == 3'(`REPORT_BYTES - 3'h1)) begin
						state    <= LINK_IDLE; // R1
						byte_idx <= 3'h0;
						bit_idx  <= 4'h0;
						line     <= 1'b1;
					end else begin
						bit_cnt  <= 16'h0;
						bit_idx  <= 4'h0;
						byte_idx <= 3'(byte_idx + 3'h1);
						line     <= 1'b0;
						// whole signed bytes, no split words R7 R9
						shift <= {1'b1, take_x ? acc_x : acc_y, 1'b0}; // R4 R6
					end
				end
				default: state <= LINK_BREAK;
			endcase
		end
	end
	// pin drive: ttl drives both levels, rs-232 inverts and only sinks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_out <= 1'b0;
			tx_oe  <= 1'b0;
		end else if (ctrl[`CTRL_TTL_BIT]) begin
			tx_out <= line; // R15
			tx_oe  <= 1'b1;
		end else begin
			tx_out <= 1'b0; // R16
			tx_oe  <= line;
		end
	end
	// report counter
	always_ff @(posedge clk) begin
		if (!rst_n)
			report_count <= 16'h0;
		else if (start_rpt)
			report_count <= 16'(report_count + 16'h1);
	end
	// axi write: address and data taken in either order, then response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			ctrl          <= `CTRL_RESET;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					`ADDR_CTRL: begin
						s_axi_bresp <= `RESP_OKAY;
						if (w_strb[0])
							ctrl <= w_data[2:0];
					end
					`ADDR_STATUS, `ADDR_COUNT, `ADDR_ACCUM: s_axi_bresp <= `RESP_SLVERR;
					default: s_axi_bresp <= `RESP_DECERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// axi read: one cycle to accept, data the cycle after
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= read_reg(s_axi_araddr);
				s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// checks on the framer and pin
	sync_byte_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
		start_rpt |=> shift[9] && shift[8:4] == 5'h10 && !shift[0])
		else $error("sync byte pattern wrong");
	sync_buttons_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
		start_rpt |=> shift[3:1] == $past(btn_db))
		else $error("sync byte buttons wrong");
	break_level_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
		state == LINK_BREAK |-> !line)
		else $error("line not at start level during break");
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		state == LINK_IDLE && $past(state) == LINK_IDLE |-> line)
		else $error("line active while idle");
	report_len_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		state == LINK_SEND && $past(state) != LINK_SEND |-> byte_idx == 3'h0)
		else $error("report did not start at byte zero");
	x_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
		take_x && !x_pulse |=> acc_x == 8'h00)
		else $error("horizontal accumulator not cleared");
	delta_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
		take_y |=> shift[8:1] == $past(acc_y) && !shift[0] && shift[9])
		else $error("vertical delta not loaded");
	ttl_pin_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		ctrl[1] && $past(ctrl[1]) |-> tx_oe && tx_out == $past(line))
		else $error("ttl pin level wrong");
	rs232_pin_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
		!ctrl[1] && $past(ctrl[1]) == 1'b0 |-> !tx_out && tx_oe == $past(line))
		else $error("rs-232 pin drive wrong");
	bit_time_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		state == LINK_SEND && $past(state) == LINK_SEND && $changed(line) |-> $past(bit_end))
		else $error("line changed inside a bit time");
endmodule : pointer_serial_packet_link

// ---- tb/host_rx.sv ----
// host uart receiver model: decodes the serial pin and keeps aligned report bytes
`timescale 1ns/10ps
`include "pointer_link_consts.svh"
module host_rx #(
	parameter int BIT_SLOW = 16,
	parameter int BIT_FAST = 8
) (
	input  wire logic clk,
	input  wire logic tx_out,
	input  wire logic tx_oe,
	input  wire logic ttl,
	input  wire logic fast
);
	logic [7:0] rx_q[$];                      // report bytes, oldest first
	int         frame_errs = 0;               // characters with a bad stop bit
	int         skipped    = 0;               // bytes dropped while hunting for sync
	int         idx        = 0;               // byte position inside a report
	int         hi         = 0;               // consecutive idle-level cycles
	bit         armed      = 0;               // set once the line has idled a bit time
	logic [7:0] sh;                           // data bits of the current character
	wire        pin  = tx_oe ? tx_out : 1'b1; // released pin is pulled up
	wire        line = ttl ? pin : ~pin;

	// bit time in clocks for the selected rate
	function automatic int bt();
		return fast ? BIT_FAST : BIT_SLOW;
	endfunction : bt

	// hold off until idle so the power-up break is not read as data
	always @(posedge clk) begin
		hi <= (line === 1'b1) ? hi + 1 : 0;
		if (hi >= bt()) armed <= 1'b1;
	end

	// sample mid-bit, lsb first, then keep only bytes of a report
	always begin
		@(posedge clk);
		if (armed && line === 1'b0) begin
			repeat (bt() / 2) @(posedge clk);
			if (line === 1'b0) begin // a short glitch is not a start bit
				for (int i = 0; i < 8; i++) begin
					repeat (bt()) @(posedge clk);
					sh[i] = line;
				end
				repeat (bt()) @(posedge clk);
				if (line !== 1'b1) frame_errs++;
				if (idx == 0 && sh[7:3] !== `SYNC_PATTERN) skipped++;
				else begin
					rx_q.push_back(sh);
					idx = (idx + 1) % 5;
				end
			end
		end
	end
endmodule : host_rx

// ---- tb/tb_pointer_serial_packet_link.sv ----
// self-checking bench for the pointer serial packet link
`timescale 1ns/10ps
`include "pointer_link_consts.svh"
module tb_pointer_serial_packet_link import pointer_link_pkg::*;;
	localparam int SLOW = 16;                 // shortened bit times
	localparam int FAST = 8;
	logic        clk = 0;                     // 50 MHz
	logic        rst_n = 0;                   // held low for 10 clocks
	logic [2:0]  button_n = 3'h7;             // all released
	logic        x_step = 0, x_right = 0, y_step = 0, y_up = 0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, rdata, d;     // d holds the last read word
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, tx_out, tx_oe;
	logic [1:0]  bresp, rresp;
	logic        ttl = 0, fast = 0;           // host uart setup
	int          num_errors = 0, tests_run = 0;

	pointer_serial_packet_link #(
		.BREAK_CYCLES(200), .DEBOUNCE_CYCLES(4), .BIT_SLOW_CYCLES(SLOW), .BIT_FAST_CYCLES(FAST)
	) u_pointer_serial_packet_link (
		.clk(clk), .rst_n(rst_n), .button_n(button_n), .x_step(x_step), .x_right(x_right),
		.y_step(y_step), .y_up(y_up), .tx_out(tx_out), .tx_oe(tx_oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	host_rx #(.BIT_SLOW(SLOW), .BIT_FAST(FAST)) u_host_rx (
		.clk(clk), .tx_out(tx_out), .tx_oe(tx_oe), .ttl(ttl), .fast(fast)
	);

	// free-running clock
	initial forever #10 clk = ~clk;

	// compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// print counts and verdict
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// one clock with a bound on the whole wait
	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 3000) begin
			num_errors++;
			$display("mismatch wait expected %h seen %h", 3000, n);
			test_done();
		end
	endtask : tick

	// axi4-lite write, address and data offered together
	task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
		int n = 0;
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			tick(n);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", 32'(bresp), 32'(er));
		@(posedge clk);
	endtask : axi_write

	// axi4-lite read, word left in d
	task automatic axi_read(input logic [3:0] a, input logic [1:0] er);
		int n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			tick(n);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		check("rresp", 32'(rresp), 32'(er));
		@(posedge clk);
	endtask : axi_read

	// cnt motion counts on one axis
	task automatic move(input bit y, input bit dir, input int cnt);
		x_right <= dir;
		y_up    <= dir;
		repeat (cnt) begin
			repeat (3) @(posedge clk);
			{y_step, x_step} <= y ? 2'b10 : 2'b01;
			repeat (3) @(posedge clk);
			{y_step, x_step} <= 2'b00;
		end
		@(posedge clk);
	endtask : move

	// five bytes as given, then silence
	task automatic expect_report(input logic [39:0] r);
		int n = 0;
		while (u_host_rx.rx_q.size() < 5) tick(n);
		for (int i = 4; i >= 0; i--) check("byte", 32'(u_host_rx.rx_q.pop_front()), 32'(r[8*i +: 8]));
		repeat (1000) @(posedge clk);
		check("extra bytes", 32'(u_host_rx.rx_q.size()), 0);
	endtask : expect_report

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		axi_read(`ADDR_CTRL, `RESP_OKAY);
		check("ctrl reset", d, 32'(`CTRL_RESET));
		axi_read(`ADDR_STATUS, `RESP_OKAY);
		check("break flag", 32'(d[0]), 1);
		check("fault flag", 32'(d[7]), 0);
		check("break pin", 32'({tx_oe, tx_out}), 0);
		axi_write(`ADDR_STATUS, 32'h0, `RESP_SLVERR);
		axi_write(4'h2, 32'h0, `RESP_DECERR);
		axi_read(4'h1, `RESP_DECERR);
		wstrb <= 4'h0;
		axi_write(`ADDR_CTRL, 32'h0, `RESP_OKAY);
		wstrb <= 4'hF;
		axi_read(`ADDR_CTRL, `RESP_OKAY);
		check("ctrl no strobe", d, 32'(`CTRL_RESET));
		axi_write(`ADDR_CTRL, 32'h0, `RESP_OKAY);
		move(0, 1, 3);
		move(1, 0, 1);
		repeat (300) @(posedge clk);
		check("idle pin", 32'({tx_oe, tx_out}), 2);
		check("bytes while off", 32'(u_host_rx.rx_q.size()), 0);
		axi_read(`ADDR_ACCUM, `RESP_OKAY);
		check("accum", 32'(d[15:0]), 32'h0000FF03);
		axi_write(`ADDR_CTRL, 32'h4, `RESP_OKAY);
		repeat (200) @(posedge clk);
		move(0, 1, 2);
		expect_report(40'h8703FF0200);
		button_n <= 3'h3;
		expect_report(40'h8300000000);
		axi_write(`ADDR_CTRL, 32'h7, `RESP_OKAY);
		ttl  <= 1'b1;
		fast <= 1'b1;
		repeat (3) @(posedge clk);
		check("ttl idle", 32'({tx_oe, tx_out}), 3);
		button_n <= 3'h5;
		expect_report(40'h8500000000);
		axi_read(`ADDR_COUNT, `RESP_OKAY);
		check("reports", 32'(d[15:0]), 3);
		check("framing", 32'(u_host_rx.frame_errs), 0);
		check("skipped", 32'(u_host_rx.skipped), 0);
		test_done();
	end
endmodule : tb_pointer_serial_packet_link
